// File: logic/wake_and_switch_status_bank.v
`timescale 1ns/1ps
`include "wake_status_defines.vh"
module wake_and_switch_status_bank (
    input wire core_clk, // 10 MHz clock
    input wire rst_n, // Async power-on reset, low
    input wire soft_reset, // Soft reset pulse
    input wire restart, // Restart-mode entry pulse
    input wire [6:0] rd_addr, // Register read address
    output reg [7:0] rd_data, // Read data, registered
    input wire clr_req, // Clear request pulse
    input wire [6:0] clr_addr, // Register to clear
    input wire int_n_pin, // Interrupt pin level
    input wire bus_timeout_event, // Bus timeout event pulse
    input wire bus_wake_event, // Bus wake pulse
    input wire timed_wake_event, // Timer wake pulse
    input wire [2:0] wake_input_event, // Wake inputs 3..1 pulses
    input wire [1:0] general_pin_wake_event, // Pin 2..1 wake pulses
    input wire wake_from_low_power, // Wake valid from sleep/stop
    input wire wake_from_fail_safe, // Wake valid from fail-safe
    input wire [2:0] wake_input_pin, // Wake input pin levels
    input wire [2:0] cyclic_sense_en, // Wake input sampled mode
    input wire [2:0] cyclic_sample_strobe, // Sampling event per input
    input wire [1:0] general_pin, // General pin levels
    input wire [1:0] general_pin_is_gpio, // Pin selected as general pin
    input wire [1:0] general_pin_cfg_active, // Pin as wake/LS/HS
    input wire normal_or_stop, // Normal or stop mode
    input wire fail_out3_test_pin, // Development-mode strap pin
    input wire int_pullup_detect, // Pull-up detect at config
    input wire [3:0] switch_overload_event, // Switch 4..1 overload
    input wire [3:0] switch_open_load_event, // Switch 4..1 open load
    output wire bus_timeout_flag // Bus timeout flag
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    reg [2:0] wk_s1;
    reg [2:0] wk_s2;
    reg [2:0] wk_s3;
    reg [1:0] gp_s1;
    reg [1:0] gp_s2;
    reg [1:0] gp_s3;
    reg int_s1;
    reg int_s2;
    reg int_s3;
    reg fo_s1;
    reg fo_s2;
    reg fo_s3;
    reg pu_s1;
    reg pu_s2;
    reg pu_s3;
    // Three-stage capture of pin inputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wk_s1 <= 3'h0;
            wk_s2 <= 3'h0;
            wk_s3 <= 3'h0;
            gp_s1 <= 2'h0;
            gp_s2 <= 2'h0;
            gp_s3 <= 2'h0;
            int_s1 <= 1'h1;
            int_s2 <= 1'h1;
            int_s3 <= 1'h1;
            fo_s1 <= 1'h0;
            fo_s2 <= 1'h0;
            fo_s3 <= 1'h0;
            pu_s1 <= 1'h0;
            pu_s2 <= 1'h0;
            pu_s3 <= 1'h0;
        end else begin
            wk_s1 <= wake_input_pin;
            wk_s2 <= wk_s1;
            wk_s3 <= wk_s2;
            gp_s1 <= general_pin;
            gp_s2 <= gp_s1;
            gp_s3 <= gp_s2;
            int_s1 <= int_n_pin;
            int_s2 <= int_s1;
            int_s3 <= int_s2;
            fo_s1 <= fail_out3_test_pin;
            fo_s2 <= fo_s1;
            fo_s3 <= fo_s2;
            pu_s1 <= int_pullup_detect;
            pu_s2 <= pu_s1;
            pu_s3 <= pu_s2;
        end
    end
    // ************************************************************
    // Filtered levels: change accepted when stages two and three agree
    // ************************************************************
    reg [2:0] wk_f_q;
    reg [1:0] gp_f_q;
    reg int_f_q;
    reg fo_f_q;
    reg pu_f_q;
    reg int_prev_q;
    // Agreement filters
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wk_f_q <= 3'h0;
            gp_f_q <= 2'h0;
            int_f_q <= 1'h1;
            int_prev_q <= 1'h1;
            fo_f_q <= 1'h0;
            pu_f_q <= 1'h0;
        end else begin
            wk_f_q <= (wk_s2 & wk_s3) | (wk_f_q & (wk_s2 | wk_s3));
            gp_f_q <= (gp_s2 & gp_s3) | (gp_f_q & (gp_s2 | gp_s3));
            if (int_s2 == int_s3) int_f_q <= int_s2;
            int_prev_q <= int_f_q;
            if (fo_s2 == fo_s3) fo_f_q <= fo_s2;
            if (pu_s2 == pu_s3) pu_f_q <= pu_s2;
        end
    end
    wire int_fall = int_prev_q & ~int_f_q;
    // ************************************************************
    // Straps caught once after reset release
    // ************************************************************
    reg [3:0] strap_cnt_q;
    reg dev_strap_q;
    reg pullup_strap_q;
    // Latch straps once the filter has settled
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q <= 4'h0;
            dev_strap_q <= 1'h0;
            pullup_strap_q <= 1'h0;
        end else if (strap_cnt_q != `STRAP_DONE_CNT) begin
            strap_cnt_q <= strap_cnt_q + 4'h1;
            if (strap_cnt_q == `STRAP_LATCH_CNT) begin
                dev_strap_q <= fo_f_q; // [R6]
                pullup_strap_q <= pu_f_q; // [R7]
            end
        end
    end
    // ************************************************************
    // Clear decode and bus timeout guard
    // ************************************************************
    wire clr_a = clr_req & (clr_addr == `ADDR_WAKE_SRC_A);
    wire clr_b = clr_req & (clr_addr == `ADDR_WAKE_SRC_B);
    wire clr_ov = clr_req & (clr_addr == `ADDR_SW_OVERLOAD);
    wire clr_ol = clr_req & (clr_addr == `ADDR_SW_OPEN_LOAD);
    wire clr_to = clr_req & (clr_addr == `ADDR_BUS_STATUS);
    wire soft_clr = soft_reset;
    reg timeout_q;
    reg timeout_lock_q;
    // Flag locked from set until next interrupt falling edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_q <= 1'h0;
            timeout_lock_q <= 1'h0;
        end else if (soft_clr) begin
            timeout_q <= 1'h0;
            timeout_lock_q <= 1'h0;
        end else begin
            if (bus_timeout_event) begin
                timeout_q <= 1'h1; // [R18]
                timeout_lock_q <= 1'h1; // [R1]
            end else begin
                if (int_fall) timeout_lock_q <= 1'h0; // [R1]
                if (clr_to && !timeout_lock_q) timeout_q <= 1'h0; // [R1]
            end
        end
    end
    assign bus_timeout_flag = timeout_q;
    // ************************************************************
    // Wake source flags
    // ************************************************************
    wire wake_ok = wake_from_low_power | wake_from_fail_safe; // [R3]
    reg [7:0] ev_a;
    reg [7:0] ev_b;
    // Map wake events onto register A positions
    always @* begin
        ev_a = `ZERO8;
        ev_a[`BIT_BUS_WAKE] = bus_wake_event; // [R2]
        ev_a[`BIT_TIMED_WAKE] = timed_wake_event; // [R2]
        ev_a[`BIT_WAKE_IN3] = wake_input_event[2]; // [R2]
        ev_a[`BIT_WAKE_IN2] = wake_input_event[1]; // [R2]
        ev_a[`BIT_WAKE_IN1] = wake_input_event[0]; // [R2]
        if (!wake_ok) begin
            ev_a = `ZERO8;
        end
    end
    // Map general pin wakes onto register B positions
    always @* begin
        ev_b = `ZERO8;
        ev_b[`BIT_PIN2_WAKE] = general_pin_wake_event[1]; // [R4]
        ev_b[`BIT_PIN1_WAKE] = general_pin_wake_event[0]; // [R4]
        if (!wake_ok) begin
            ev_b = `ZERO8;
        end
    end
    reg [7:0] wake_a_q;
    reg [7:0] wake_b_q;
    reg [7:0] overload_q;
    reg [7:0] open_load_q;
    // Wake register A: sticky, set wins over clear
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_a_q <= `ZERO8; // [R15]
        end else if (soft_clr) begin
            wake_a_q <= `ZERO8; // [R15]
        end else if (restart) begin
            wake_a_q <= wake_a_q & `WAKE_A_MASK; // [R16]
        end else begin
            wake_a_q <= ((clr_a ? `ZERO8 : wake_a_q) | ev_a) & `WAKE_A_MASK; // [R18]
        end
    end
    // Wake register B: sticky, set wins over clear
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_b_q <= `ZERO8; // [R15]
        end else if (soft_clr) begin
            wake_b_q <= `ZERO8; // [R15]
        end else if (restart) begin
            wake_b_q <= wake_b_q & `WAKE_B_MASK;
        end else begin
            wake_b_q <= ((clr_b ? `ZERO8 : wake_b_q) | ev_b) & `WAKE_B_MASK; // [R18]
        end
    end
    // Overload register: one sticky flag per switch
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overload_q <= `ZERO8; // [R15]
        end else if (soft_clr) begin
            overload_q <= `ZERO8; // [R15]
        end else if (restart) begin
            overload_q <= overload_q & `SW_MASK; // [R17]
        end else begin
            overload_q <= (clr_ov ? `ZERO8 : overload_q) | {4'h0, switch_overload_event}; // [R12]
        end
    end
    // Open-load register: one sticky flag per switch
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            open_load_q <= `ZERO8; // [R15]
        end else if (soft_clr) begin
            open_load_q <= `ZERO8; // [R15]
        end else if (restart) begin
            open_load_q <= open_load_q & `SW_MASK; // [R17]
        end else begin
            open_load_q <= (clr_ol ? `ZERO8 : open_load_q) | {4'h0, switch_open_load_event}; // [R13]
        end
    end
    // ************************************************************
    // Level mirror
    // ************************************************************
    reg [2:0] wk_lvl_q;
    reg [1:0] gp_lvl_q;
    integer i;
    integer j;
    // Wake inputs follow the pin live, or once per sample in cyclic mode
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wk_lvl_q <= 3'h0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                if (!cyclic_sense_en[i] || cyclic_sample_strobe[i]) begin
                    wk_lvl_q[i] <= wk_f_q[i]; // [R5] [R9]
                end
            end
        end
    end
    // General pins are never sampled cyclically
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp_lvl_q <= 2'h0;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                if (normal_or_stop && (general_pin_cfg_active[j] || general_pin_is_gpio[j])) begin
                    gp_lvl_q[j] <= gp_f_q[j]; // [R8] [R10] [R11]
                end
            end
        end
    end
    // ************************************************************
    // Named fields and read words
    // ************************************************************
    // Wake source fields
    wire bus_wake_flag = wake_a_q[`BIT_BUS_WAKE];
    wire timed_wake_flag = wake_a_q[`BIT_TIMED_WAKE];
    wire wake_input3_flag = wake_a_q[`BIT_WAKE_IN3];
    wire wake_input2_flag = wake_a_q[`BIT_WAKE_IN2];
    wire wake_input1_flag = wake_a_q[`BIT_WAKE_IN1];
    wire general_pin2_wake_flag = wake_b_q[`BIT_PIN2_WAKE];
    wire general_pin1_wake_flag = wake_b_q[`BIT_PIN1_WAKE];
    // Per-switch fault fields
    wire switch4_overload_flag = overload_q[`BIT_SW4];
    wire switch3_overload_flag = overload_q[`BIT_SW3];
    wire switch2_overload_flag = overload_q[`BIT_SW2];
    wire switch1_overload_flag = overload_q[`BIT_SW1];
    wire switch4_open_load_flag = open_load_q[`BIT_SW4];
    wire switch3_open_load_flag = open_load_q[`BIT_SW3];
    wire switch2_open_load_flag = open_load_q[`BIT_SW2];
    wire switch1_open_load_flag = open_load_q[`BIT_SW1];
    // Level fields
    wire development_mode_strap = dev_strap_q;
    wire pullup_config_strap = pullup_strap_q;
    wire general_pin2_level = gp_lvl_q[1];
    wire general_pin1_level = gp_lvl_q[0];
    wire wake_input3_level = wk_lvl_q[2];
    wire wake_input2_level = wk_lvl_q[1];
    wire wake_input1_level = wk_lvl_q[0];
    // Read words, reserved positions tied low
    wire [7:0] wake_a_word = {2'h0, bus_wake_flag, timed_wake_flag, 1'h0,
        wake_input3_flag, wake_input2_flag, wake_input1_flag}; // [R14]
    wire [7:0] wake_b_word = {2'h0, general_pin2_wake_flag, general_pin1_wake_flag,
        4'h0}; // [R14]
    wire [7:0] overload_word = {4'h0, switch4_overload_flag, switch3_overload_flag,
        switch2_overload_flag, switch1_overload_flag}; // [R14]
    wire [7:0] open_load_word = {4'h0, switch4_open_load_flag, switch3_open_load_flag,
        switch2_open_load_flag, switch1_open_load_flag}; // [R14]
    wire [7:0] lvl_word = {development_mode_strap, pullup_config_strap,
        general_pin2_level, general_pin1_level, 1'h0,
        wake_input3_level, wake_input2_level, wake_input1_level}; // [R14]
    wire [7:0] bus_status_word = {3'h0, timeout_q, 4'h0}; // [R14]
    // ************************************************************
    // Read port
    // ************************************************************
    // Registered read data, unmapped reads zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `ZERO8;
        end else begin
            case (rd_addr)
                `ADDR_WAKE_SRC_A: rd_data <= wake_a_word;
                `ADDR_WAKE_SRC_B: rd_data <= wake_b_word;
                `ADDR_WAKE_LVL: rd_data <= lvl_word;
                `ADDR_SW_OVERLOAD: rd_data <= overload_word;
                `ADDR_SW_OPEN_LOAD: rd_data <= open_load_word;
                `ADDR_BUS_STATUS: rd_data <= bus_status_word; // [R14]
                default: rd_data <= `ZERO8;
            endcase
        end
    end
endmodule // wake_and_switch_status_bank

// File: logic/wake_status_defines.vh
// Summary of operation
// [R1] Bus timeout clear blocked until interrupt falls
// [R2] Wake register A: bus5 timer4 inputs2..0
// [R3] Fail-safe wakes also set source flags
// [R4] Wake register B: pin2 bit5, pin1 bit4
// [R5] Level register bits2..0 show wake inputs
// [R6] Level bit7 shows development mode strap
// [R7] Level bit6 shows pull-up configuration strap
// [R8] Pin levels refreshed in normal/stop if configured
// [R9] Cyclic sense: levels updated per sample
// [R10] No cyclic sensing on general pins
// [R11] Pin level shown even when driving switch
// [R12] Overload register bits3..0 per switch
// [R13] Open-load register bits3..0 per switch
// [R14] Reserved bits always read zero
// [R15] Power-on/soft reset clears flag registers
// [R16] Restart keeps wake register A and B flags
// [R17] Restart keeps switch flags, clears upper nibble
// [R18] Flags sticky until clear; new event wins
`ifndef WAKE_STATUS_DEFINES_VH
`define WAKE_STATUS_DEFINES_VH
`define ADDR_WAKE_SRC_A 7'h46
`define ADDR_WAKE_SRC_B 7'h47
`define ADDR_WAKE_LVL 7'h48
`define ADDR_SW_OVERLOAD 7'h54
`define ADDR_SW_OPEN_LOAD 7'h55
`define ADDR_BUS_STATUS 7'h44
`define WAKE_A_MASK 8'h37
`define WAKE_B_MASK 8'h30
`define SW_MASK 8'h0f
`define BIT_BUS_TIMEOUT 4
`define BIT_BUS_WAKE 5
`define BIT_TIMED_WAKE 4
`define BIT_PIN2_WAKE 5
`define BIT_PIN1_WAKE 4
`define BIT_DEV_STRAP 7
`define BIT_PULLUP_STRAP 6
`define BIT_PIN2_LVL 5
`define BIT_PIN1_LVL 4
`define BIT_WAKE_IN3 2
`define BIT_WAKE_IN2 1
`define BIT_WAKE_IN1 0
`define BIT_SW4 3
`define BIT_SW3 2
`define BIT_SW2 1
`define BIT_SW1 0
`define STRAP_LATCH_CNT 4'h7
`define STRAP_DONE_CNT 4'h8
`define ZERO8 8'h00
`endif

// File: verification/serial_host.sv
`timescale 1ns/1ps
// ****
// Host side of the status access
// ****
module serial_host (
    input wire core_clk, // Clock
    input wire [7:0] rd_data, // Read data from the bank
    output reg [6:0] rd_addr = 7'h00, // Read address, held
    output reg clr_req = 1'b0, // Clear pulse
    output reg [6:0] clr_addr = 7'h00 // Register to clear
);
    // Address set after one edge, data taken after the next
    task rd(input [6:0] a, output [7:0] d);
        @(posedge core_clk) rd_addr <= a;
        @(posedge core_clk) #1 d = rd_data;
    endtask
    // One-cycle clear command for one register
    task clr(input [6:0] a);
        @(posedge core_clk) {clr_req, clr_addr} <= {1'b1, a};
        @(posedge core_clk) clr_req <= 1'b0;
    endtask
endmodule // serial_host

// File: verification/wake_status_monitor.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module wake_status_monitor (
    input wire core_clk, input wire rst_n, input wire soft_reset, input wire restart,
    input wire [6:0] rd_addr, input wire [7:0] rd_data, input wire int_n_pin,
    input wire bus_timeout_event, input wire bus_wake_event, input wire wake_from_fail_safe,
    input wire [3:0] switch_open_load_event, input wire bus_timeout_flag
);
    reg [3:0] hi_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the interrupt pin was last low
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n) hi_q <= 4'h0;
        else if (!int_n_pin) hi_q <= 4'h0;
        else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
    property p_rsv_a; rd_addr == 7'h46 |=> (rd_data & 8'hc8) == 8'h00; endproperty
    a_rsv_a: assert property (p_rsv_a) else $error("wake A reserved set");
    property p_rsv_b; rd_addr == 7'h47 |=> (rd_data & 8'hcf) == 8'h00; endproperty
    a_rsv_b: assert property (p_rsv_b) else $error("wake B reserved set");
    property p_sw_hi; rd_addr[6:1] == 6'h2a |=> rd_data[7:4] == 4'h0; endproperty
    a_sw_hi: assert property (p_sw_hi) else $error("switch upper nibble set");
    property p_to_set; bus_timeout_event && !soft_reset && !restart |=> bus_timeout_flag;
    endproperty
    a_to_set: assert property (p_to_set) else $error("timeout flag not set");
    property p_to_hold; $rose(bus_timeout_flag) && hi_q > 4'h8 ##1
        (int_n_pin && !soft_reset && !restart) [*6] |-> bus_timeout_flag; endproperty
    a_to_hold: assert property (p_to_hold) else $error("timeout flag lost");
    property p_wake; bus_wake_event && wake_from_fail_safe && !soft_reset && !restart ##1
        rd_addr == 7'h46 |=> rd_data[5]; endproperty
    a_wake: assert property (p_wake) else $error("bus wake not recorded");
    property p_open; |switch_open_load_event && !soft_reset && !restart ##1 rd_addr == 7'h55 |=>
        (rd_data[3:0] & $past(switch_open_load_event, 2)) == $past(switch_open_load_event, 2);
    endproperty
    a_open: assert property (p_open) else $error("open load not recorded");
    property p_soft; soft_reset ##1 rd_addr == 7'h54 |=> rd_data == 8'h00; endproperty
    a_soft: assert property (p_soft) else $error("soft reset kept flags");
    c_fs: cover property (bus_wake_event && wake_from_fail_safe);
    c_fall: cover property ($fell(bus_timeout_flag));
    c_soft: cover property (soft_reset);
endmodule // wake_status_monitor
bind wake_and_switch_status_bank wake_status_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .restart(restart), .rd_addr(rd_addr), .rd_data(rd_data),
    .int_n_pin(int_n_pin), .bus_timeout_event(bus_timeout_event),
    .bus_wake_event(bus_wake_event), .wake_from_fail_safe(wake_from_fail_safe),
    .switch_open_load_event(switch_open_load_event), .bus_timeout_flag(bus_timeout_flag));

// File: verification/wake_and_switch_status_bank_tb.sv
`timescale 1ns/1ps
// ****
// Status bank bench
// ****
module wake_and_switch_status_bank_tb;
    reg core_clk = 1'b0, rst_n = 1'b0, int_n = 1'b1, lowp = 1'b1, fsafe = 1'b0;
    reg [17:0] ev_v = 18'h0;
    reg [2:0] wk_pin = 3'h5, cyc_en = 3'h0, cyc_stb = 3'h0;
    reg [1:0] gp_pin = 2'h2, gp_sel = 2'h3, gp_cfg = 2'h0;
    reg nos = 1'b1;
    reg [7:0] d;
    wire [6:0] rd_addr, clr_addr;
    wire [7:0] rd_data;
    wire clr_req, bus_timeout_flag;
    integer n_fail = 0, comparisons = 0, i;
    always #50 core_clk = ~core_clk;
    // Event pulses packed: soft, restart, bus, timer, inputs, pins, overload, open, timeout
    wake_and_switch_status_bank dut (.core_clk(core_clk), .rst_n(rst_n), .soft_reset(ev_v[17]),
        .restart(ev_v[16]), .rd_addr(rd_addr), .rd_data(rd_data), .clr_req(clr_req),
        .clr_addr(clr_addr), .int_n_pin(int_n), .bus_timeout_event(ev_v[0]),
        .bus_wake_event(ev_v[15]), .timed_wake_event(ev_v[14]), .wake_input_event(ev_v[13:11]),
        .general_pin_wake_event(ev_v[10:9]), .wake_from_low_power(lowp),
        .wake_from_fail_safe(fsafe), .wake_input_pin(wk_pin), .cyclic_sense_en(cyc_en),
        .cyclic_sample_strobe(cyc_stb), .general_pin(gp_pin), .general_pin_is_gpio(gp_sel),
        .general_pin_cfg_active(gp_cfg), .normal_or_stop(nos), .fail_out3_test_pin(1'b1),
        .int_pullup_detect(1'b0), .switch_overload_event(ev_v[8:5]),
        .switch_open_load_event(ev_v[4:1]), .bus_timeout_flag(bus_timeout_flag));
    serial_host host (.core_clk(core_clk), .rd_data(rd_data), .rd_addr(rd_addr),
        .clr_req(clr_req), .clr_addr(clr_addr));
    // Flag register address by index: wake A, wake B, overload, open load
    function [6:0] ad(input integer k);
        ad = {k[1] ? 6'h2a : 6'h23, k[0]};
    endfunction
    task cmp(input [7:0] g, input [7:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    task chk(input [6:0] a, input [7:0] e);
        host.rd(a, d);
        cmp(d, e);
    endtask
    task chk4(input [31:0] x);
        integer k;
        for (k = 0; k < 4; k = k + 1) chk(ad(k), x[8*k +: 8]);
    endtask
    task ev(input [17:0] v);
        @(posedge core_clk) ev_v <= v;
        @(posedge core_clk) ev_v <= 18'h0;
        #1;
    endtask
    task test_done;
        $display("fails %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk4(32'h0);
        chk(7'h48, 8'ha5);
        ev(18'h0acb4);
        chk4(32'h0a052025);
        ev(18'h0534a);
        chk4(32'h0f0f3037);
        for (i = 0; i < 4; i = i + 1) host.clr(ad(i));
        chk4(32'h0);
        chk(7'h46, 8'h00);
        lowp <= 1'b0;
        fsafe <= 1'b1;
        ev(18'h08000);
        chk(7'h46, 8'h20);
        ev(18'h000a0);
        chk(7'h54, 8'h05);
        ev(18'h10000);
        chk(7'h46, 8'h20);
        chk(7'h54, 8'h05);
        ev(18'h20000);
        chk4(32'h0);
        ev(18'h00001);
        cmp({7'h0, bus_timeout_flag}, 8'h01);
        host.clr(7'h44);
        repeat (6) @(posedge core_clk);
        cmp({7'h0, bus_timeout_flag}, 8'h01);
        int_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        int_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        host.clr(7'h44);
        @(posedge core_clk) #1 cmp({7'h0, bus_timeout_flag}, 8'h00);
        cyc_en <= 3'h1;
        wk_pin <= 3'h4;
        gp_pin <= 2'h1;
        repeat (12) @(posedge core_clk);
        chk(7'h48, 8'h95);
        cyc_stb <= 3'h1;
        @(posedge core_clk) cyc_stb <= 3'h0;
        repeat (4) @(posedge core_clk);
        chk(7'h48, 8'h94);
        @(posedge core_clk);
        gp_sel <= 2'h0;
        gp_pin <= 2'h2;
        repeat (8) @(posedge core_clk);
        chk(7'h48, 8'h94);
        gp_cfg <= 2'h3;
        repeat (8) @(posedge core_clk);
        chk(7'h48, 8'ha4);
        nos <= 1'b0;
        gp_pin <= 2'h1;
        repeat (8) @(posedge core_clk);
        chk(7'h48, 8'ha4);
        test_done;
    end
    // Watchdog against a hung sequence
    initial begin
        #200000;
        n_fail = n_fail + 1;
        test_done;
    end
endmodule // wake_and_switch_status_bank_tb
